/* logic/ucg_gpio.sv */
// pin function select, direction, level and change-mask block
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module ucg_gpio #(
   parameter int unsigned NPINS = ucg_pkg::NPINS
) (
   input  wire logic                       clock,         // core clock, 40 MHz
   input  wire logic                       reset,         // synchronous, active high
   input  wire logic [ucg_pkg::ADDR_W-1:0] addr,          // register address
   input  wire logic [ucg_pkg::DATA_W-1:0] wr_data,       // write data
   input  wire logic                       wr_en,         // write strobe
   input  wire logic                       rd_en,         // read strobe
   output logic      [ucg_pkg::DATA_W-1:0] rd_data,       // read data, next cycle
   input  wire logic [NPINS-1:0]           pin_in,        // pin levels from pads
   output logic      [NPINS-1:0]           pin_out,       // pin drive value
   output logic      [NPINS-1:0]           pin_oe,        // pin drive enable
   input  wire logic                       tx_active,     // uart is transmitting
   input  wire logic                       addr_match,    // address match in force
   input  wire logic                       bit_tick,      // one pulse per bit time
   input  wire logic                       rx_char,       // pulse per received char
   input  wire logic                       tx_char,       // pulse per sent char
   input  wire logic                       clk_out_level, // configured clock output
   input  wire logic                       rts_request,   // uart ready to receive
   input  wire logic                       dtr_request,   // uart terminal ready
   output logic                            cts_ok,        // clear to send seen
   output logic                            dsr_ok,        // data set ready seen
   output logic      [NPINS-1:0]           pin_state,     // current pin levels
   output logic                            irq_request,   // change interrupt pulse
   output logic      [NPINS-1:0]           irq_pins       // pins that changed
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic drive_de(input logic de, input logic hi);
      drive_de = hi ? de : ~de;
   endfunction

   function automatic logic [NPINS-1:0] low_bits(input logic [15:0] d);
      low_bits = d[NPINS-1:0];
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [NPINS-1:0]             pin_sync;
   logic [NPINS-1:0]             func_q;
   logic [NPINS-1:0]             dir_q;
   logic [NPINS-1:0]             out_q;
   logic [NPINS-1:0]             out_d;
   logic [NPINS-1:0]             mask_q;
   logic [ucg_pkg::TURN_W-1:0]   turn_q;
   logic [ucg_pkg::TURN_W-1:0]   hold_q;
   logic [ucg_pkg::TURN_W-1:0]   hold_d;
   ucg_pkg::ucg_de_state_t       de_q;
   ucg_pkg::ucg_de_state_t       de_d;
   logic                         rx_tog_q;
   logic                         tx_tog_q;
   logic [NPINS-1:0]             prev_q;
   logic [2:0]                   primed_q;
   logic [NPINS-1:0]             pin_out_q;
   logic [NPINS-1:0]             pin_oe_q;
   logic [ucg_pkg::DATA_W-1:0]   rd_data_q;
   logic                         cts_ok_q;
   logic                         dsr_ok_q;
   logic [NPINS-1:0]             pin_state_q;
   logic                         irq_q;
   logic [NPINS-1:0]             irq_pins_q;

   // ----------------------------------------------------------------
   // input synchroniser
   // ----------------------------------------------------------------
   ucg_sync #(
      .WIDTH    (NPINS)
   ) u_sync (
      .clock    (clock),
      .reset    (reset),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire              wr_func  = wr_en && (addr == ucg_pkg::OFS_FUNC);
   wire              wr_dir   = wr_en && (addr == ucg_pkg::OFS_DIR);
   wire              wr_set   = wr_en && (addr == ucg_pkg::OFS_SET);
   wire              wr_clr   = wr_en && (addr == ucg_pkg::OFS_CLR);
   wire              wr_level = wr_en && (addr == ucg_pkg::OFS_LEVEL);
   wire              wr_mask  = wr_en && (addr == ucg_pkg::OFS_MASK);
   wire              wr_turn  = wr_en && (addr == ucg_pkg::OFS_TURN);
   wire [NPINS-1:0]  wd       = low_bits(wr_data); // upper bits dropped

   // ----------------------------------------------------------------
   // function select fields
   // ----------------------------------------------------------------
   wire [2:0] p5_code  = func_q[ucg_pkg::F_P5_HI:ucg_pkg::F_P5_LO];
   wire [1:0] p7_code  = func_q[ucg_pkg::F_P7_HI:ucg_pkg::F_P7_LO];
   wire       p7_route = func_q[ucg_pkg::F_ROUTE];
   wire       de_hi    = func_q[ucg_pkg::F_POL];

   // pin 5 keeps its own field; software keeps it apart from pin 7
   wire alt_rts   = (p5_code == ucg_pkg::M_RTS_CTS);
   wire alt_dtr   = (p5_code == ucg_pkg::M_DTR_DSR);
   wire p5_de_tx  = (p5_code == ucg_pkg::M_DE_TX);
   wire p5_de_adr = (p5_code == ucg_pkg::M_DE_ADDR);
   wire alt_p5    = alt_rts || p5_de_tx || p5_de_adr;

   wire p7_de_tx  = p7_route && (p7_code == ucg_pkg::P7_DE_TX);
   wire p7_de_adr = p7_route && (p7_code == ucg_pkg::P7_DE_ADDR);
   wire alt_p7    = p7_de_tx || p7_de_adr;

   // ----------------------------------------------------------------
   // alternate function map
   // ----------------------------------------------------------------
   logic [NPINS-1:0] alt_mask;
   logic [NPINS-1:0] alt_in;
   logic [NPINS-1:0] alt_val;

   always_comb begin
      alt_mask = '0;
      alt_mask[ucg_pkg::PIN_RX_TOG] = func_q[ucg_pkg::F_RX_TOG];
      alt_mask[ucg_pkg::PIN_TX_TOG] = func_q[ucg_pkg::F_TX_TOG];
      alt_mask[ucg_pkg::PIN_CLK]    = func_q[ucg_pkg::F_CLK];
      alt_mask[ucg_pkg::PIN_DE7]    = alt_p7;
      alt_mask[ucg_pkg::PIN_RTS]    = alt_p5;
      alt_mask[ucg_pkg::PIN_CTS]    = alt_rts;
      alt_mask[ucg_pkg::PIN_DSR]    = alt_dtr;
      alt_mask[ucg_pkg::PIN_DTR]    = alt_dtr;
   end

   always_comb begin
      alt_in = '0;
      alt_in[ucg_pkg::PIN_CTS] = alt_rts;
      alt_in[ucg_pkg::PIN_DSR] = alt_dtr;
   end

   // driver enable level, then pin 5 and pin 7 values, polarity applied in the enable modes
   wire de_tx  = (de_q != ucg_pkg::DE_IDLE);
   wire p5_val = alt_rts  ? ~rts_request
               : p5_de_tx ? drive_de(de_tx, de_hi)
               :            drive_de(addr_match, de_hi);
   wire p7_val = p7_de_tx ? drive_de(de_tx, de_hi)
               :            drive_de(addr_match, de_hi);

   always_comb begin
      alt_val = '0;
      alt_val[ucg_pkg::PIN_RX_TOG] = rx_tog_q;
      alt_val[ucg_pkg::PIN_TX_TOG] = tx_tog_q;
      alt_val[ucg_pkg::PIN_CLK]    = clk_out_level;
      alt_val[ucg_pkg::PIN_DE7]    = p7_val;
      alt_val[ucg_pkg::PIN_RTS]    = p5_val;
      alt_val[ucg_pkg::PIN_DTR]    = ~dtr_request;
   end

   // ----------------------------------------------------------------
   // general purpose output latch
   // ----------------------------------------------------------------
   // only pins in general function and set as outputs take writes
   wire [NPINS-1:0] gp_out = ~alt_mask & dir_q;

   always_comb begin
      out_d = out_q;
      if (wr_set) begin
         out_d = out_q | (wd & gp_out);
      end else if (wr_clr) begin
         out_d = out_q & ~(wd & gp_out);
      end else if (wr_level) begin
         out_d = (out_q & ~gp_out) | (wd & gp_out);
      end
   end

   wire [NPINS-1:0] oe_d  = (alt_mask & ~alt_in) | (~alt_mask & dir_q);
   wire [NPINS-1:0] val_d = (alt_mask & alt_val) | (~alt_mask & out_q);

   // ----------------------------------------------------------------
   // driver enable sequencer
   // ----------------------------------------------------------------
   wire hold_zero = (turn_q == '0);
   wire hold_last = (hold_q == ucg_pkg::TURN_W'(1));

   always_comb begin
      de_d   = de_q;
      hold_d = hold_q;
      unique case (de_q)
         ucg_pkg::DE_IDLE: begin
            if (tx_active) begin
               de_d = ucg_pkg::DE_SEND;
            end
         end
         ucg_pkg::DE_SEND: begin
            if (!tx_active) begin
               if (hold_zero) begin
                  de_d = ucg_pkg::DE_IDLE;
               end else begin
                  de_d   = ucg_pkg::DE_HOLD;
                  hold_d = turn_q;
               end
            end
         end
         ucg_pkg::DE_HOLD: begin
            if (tx_active) begin
               de_d = ucg_pkg::DE_SEND;
            end else if (bit_tick) begin
               hold_d = hold_q - ucg_pkg::TURN_W'(1);
               if (hold_last) begin
                  de_d = ucg_pkg::DE_IDLE;
               end
            end
         end
         default: begin
            de_d   = ucg_pkg::DE_IDLE;
            hold_d = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // change detection
   // ----------------------------------------------------------------
   // outputs are never watched; the mask gates the rest
   wire [NPINS-1:0] moved   = (pin_sync ^ prev_q) & ~pin_oe_q;
   // sync chain restarts from zero: no reports until it has refilled
   wire [NPINS-1:0] changed = primed_q[2] ? (moved & ~mask_q) : '0;

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   logic [ucg_pkg::DATA_W-1:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      unique case (addr)
         ucg_pkg::OFS_FUNC:  rd_mux[NPINS-1:0]          = func_q;
         ucg_pkg::OFS_DIR:   rd_mux[NPINS-1:0]          = dir_q;
         ucg_pkg::OFS_LEVEL: rd_mux[NPINS-1:0]          = pin_sync;
         ucg_pkg::OFS_MASK:  rd_mux[NPINS-1:0]          = mask_q;
         ucg_pkg::OFS_TURN:  rd_mux[ucg_pkg::TURN_W-1:0] = turn_q;
         default:            rd_mux                     = '0;
      endcase
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         func_q <= ucg_pkg::FUNC_RST;
         dir_q  <= ucg_pkg::DIR_RST;
         mask_q <= ucg_pkg::MASK_RST;
         turn_q <= ucg_pkg::TURN_RST;
         out_q  <= ucg_pkg::OUT_RST;
      end else begin
         if (wr_func) func_q <= wd;
         if (wr_dir)  dir_q  <= wd;
         if (wr_mask) mask_q <= wd;
         if (wr_turn) turn_q <= wr_data[ucg_pkg::TURN_W-1:0];
         out_q <= out_d;
      end
   end

   // ----------------------------------------------------------------
   // activity toggles and sequencer state
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         rx_tog_q <= 1'b0;
         tx_tog_q <= 1'b0;
         de_q     <= ucg_pkg::DE_IDLE;
         hold_q   <= '0;
      end else begin
         rx_tog_q <= rx_tog_q ^ rx_char;
         tx_tog_q <= tx_tog_q ^ tx_char;
         de_q     <= de_d;
         hold_q   <= hold_d;
      end
   end

   // ----------------------------------------------------------------
   // pin drive and handshake outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         pin_out_q <= '0;
         pin_oe_q  <= '0;
         cts_ok_q  <= 1'b0;
         dsr_ok_q  <= 1'b0;
      end else begin
         pin_out_q <= val_d;
         pin_oe_q  <= oe_d;
         cts_ok_q  <= alt_rts & ~pin_sync[ucg_pkg::PIN_CTS];
         dsr_ok_q  <= alt_dtr & ~pin_sync[ucg_pkg::PIN_DSR];
      end
   end

   // ----------------------------------------------------------------
   // readback and change reporting
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         rd_data_q   <= '0;
         prev_q      <= '0;
         primed_q    <= 3'h0;
         pin_state_q <= '0;
         irq_q       <= 1'b0;
         irq_pins_q  <= '0;
      end else begin
         rd_data_q   <= rd_en ? rd_mux : '0;
         prev_q      <= pin_sync;
         primed_q    <= {primed_q[1:0], 1'b1};
         pin_state_q <= pin_sync;
         irq_q       <= |changed;
         irq_pins_q  <= changed;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rd_data     = rd_data_q;
   assign pin_out     = pin_out_q;
   assign pin_oe      = pin_oe_q;
   assign cts_ok      = cts_ok_q;
   assign dsr_ok      = dsr_ok_q;
   assign pin_state   = pin_state_q;
   assign irq_request = irq_q;
   assign irq_pins    = irq_pins_q;

endmodule

`default_nettype wire

/* logic/ucg_pkg.sv */
// constants for the per-channel pin function, direction and level block
package ucg_pkg;

   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int unsigned NPINS   = 10;
   localparam int unsigned DATA_W  = 16;
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned TURN_W  = 4;

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_TURN  = 8'h0B;
   localparam logic [7:0] OFS_FUNC  = 8'h0C;
   localparam logic [7:0] OFS_DIR   = 8'h0D;
   localparam logic [7:0] OFS_SET   = 8'h0E;
   localparam logic [7:0] OFS_CLR   = 8'h0F;
   localparam logic [7:0] OFS_LEVEL = 8'h10;
   localparam logic [7:0] OFS_MASK  = 8'h11;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [9:0] FUNC_RST = 10'h300;
   localparam logic [9:0] DIR_RST  = 10'h000;
   localparam logic [9:0] OUT_RST  = 10'h000;
   localparam logic [9:0] MASK_RST = 10'h100;
   localparam logic [3:0] TURN_RST = 4'h0;

   // -----------------------------------------------------------------
   // function select field positions
   // -----------------------------------------------------------------
   localparam int unsigned F_RX_TOG = 9;
   localparam int unsigned F_TX_TOG = 8;
   localparam int unsigned F_CLK    = 7;
   localparam int unsigned F_P7_HI  = 6;
   localparam int unsigned F_P7_LO  = 5;
   localparam int unsigned F_ROUTE  = 4;
   localparam int unsigned F_POL    = 3;
   localparam int unsigned F_P5_HI  = 2;
   localparam int unsigned F_P5_LO  = 0;

   // -----------------------------------------------------------------
   // function codes
   // -----------------------------------------------------------------
   localparam logic [1:0] P7_GPIO    = 2'h0;
   localparam logic [1:0] P7_DE_TX   = 2'h1;
   localparam logic [1:0] P7_DE_ADDR = 2'h2;
   localparam logic [2:0] M_GPIO     = 3'h0;
   localparam logic [2:0] M_RTS_CTS  = 3'h1;
   localparam logic [2:0] M_DTR_DSR  = 3'h2;
   localparam logic [2:0] M_DE_TX    = 3'h3;
   localparam logic [2:0] M_DE_ADDR  = 3'h4;

   // -----------------------------------------------------------------
   // pin positions of alternate functions
   // -----------------------------------------------------------------
   localparam int unsigned PIN_DTR    = 2;
   localparam int unsigned PIN_DSR    = 3;
   localparam int unsigned PIN_CTS    = 4;
   localparam int unsigned PIN_RTS    = 5;
   localparam int unsigned PIN_CLK    = 6;
   localparam int unsigned PIN_DE7    = 7;
   localparam int unsigned PIN_TX_TOG = 8;
   localparam int unsigned PIN_RX_TOG = 9;

   // -----------------------------------------------------------------
   // driver enable sequencer
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      DE_IDLE = 3'b001,
      DE_SEND = 3'b010,
      DE_HOLD = 3'b100
   } ucg_de_state_t;

endpackage

/* logic/ucg_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module ucg_sync #(
   parameter int unsigned WIDTH = 10
) (
   input  wire logic             clock,     // core clock
   input  wire logic             reset,     // synchronous, active high
   input  wire logic [WIDTH-1:0] async_in,  // raw pin levels
   output logic      [WIDTH-1:0] sync_out   // levels in core domain
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

`default_nettype wire

/* verification/ucg_pad_model.sv */
// pad model: driven pins loop back, others follow the far side
`timescale 1ns/100ps
`default_nettype none

module ucg_pad_model (
   input  wire logic [9:0] pin_out,   // device drive value
   input  wire logic [9:0] pin_oe,    // device drive enable
   input  wire logic [9:0] ext_level, // far side level
   output logic      [9:0] pin_in     // resolved pad level
);
   assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

`default_nettype wire

/* verification/ucg_gpio_properties.sv */
// concurrent checks on the pin control block ports
`timescale 1ns/100ps
`default_nettype none

module ucg_gpio_chk #(
   parameter int unsigned NPINS = 10
) (
   input wire logic             clock,       // core clock
   input wire logic             reset,       // sync reset
   input wire logic [7:0]       addr,        // address
   input wire logic [15:0]      wr_data,     // write data
   input wire logic             wr_en,       // write strobe
   input wire logic             rd_en,       // read strobe
   input wire logic [15:0]      rd_data,     // read data
   input wire logic [NPINS-1:0] pin_in,      // pad levels
   input wire logic [NPINS-1:0] pin_out,     // drive value
   input wire logic [NPINS-1:0] pin_oe,      // drive enable
   input wire logic             tx_active,   // transmitting
   input wire logic             cts_ok,      // clear to send
   input wire logic [NPINS-1:0] pin_state,   // synced levels
   input wire logic             irq_request, // change pulse
   input wire logic [NPINS-1:0] irq_pins     // changed pins
);
   // -----------------------------------------------------------------
   // shadow state
   // -----------------------------------------------------------------
   logic [1:0] since_q;
   logic [9:0] func_q;
   logic [9:0] mask_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         since_q <= 2'h0;
         func_q  <= 10'h300;
         mask_q  <= 10'h100;
      end else begin
         if (since_q != 2'h3) since_q <= since_q + 2'h1;
         if (wr_en && addr == ucg_pkg::OFS_FUNC) func_q <= wr_data[9:0];
         if (wr_en && addr == ucg_pkg::OFS_MASK) mask_q <= wr_data[9:0];
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   chk_read_window: assert property (
      (!$past(rd_en) || $past(addr) == ucg_pkg::OFS_SET) |-> rd_data == 16'h0000)
      else $error("read data outside read window");
   chk_sync_depth: assert property (
      since_q == 2'h3 |-> pin_state == $past(pin_in, 3))
      else $error("pin state not three cycles behind pads");
   chk_dir_drive: assert property (
      wr_en && addr == ucg_pkg::OFS_DIR |-> ##3 pin_oe[1:0] == $past(wr_data[1:0], 3))
      else $error("direction write not reflected in enables");
   chk_set_high: assert property (
      wr_en && addr == ucg_pkg::OFS_SET && pin_oe[0] && wr_data[0] |-> ##3 pin_out[0])
      else $error("set strobe did not drive pin high");
   chk_clear_low: assert property (
      wr_en && addr == ucg_pkg::OFS_CLR && pin_oe[0] && wr_data[0] |-> ##3 !pin_out[0])
      else $error("clear strobe did not drive pin low");
   chk_toggle_drive: assert property (
      since_q == 2'h3 && func_q[9:8] == 2'b11 && $past(func_q[9:8], 2) == 2'b11
      |-> pin_oe[9:8] == 2'b11)
      else $error("toggle pins not driven");
   chk_de_transmit: assert property (
      func_q[2:0] == 3'h3 && $past(func_q, 2) == func_q && $past(tx_active, 2)
      |-> pin_oe[5] && pin_out[5] == func_q[3])
      else $error("transmit enable level wrong");
   chk_cts_follow: assert property (
      since_q == 2'h3 && func_q[2:0] == 3'h1 && $past(func_q[2:0]) == 3'h1
      |-> cts_ok == !pin_state[4])
      else $error("clear to send does not follow pin 4");
   chk_mask_gate: assert property (
      irq_request && $past(mask_q, 4) == mask_q |-> (irq_pins & mask_q) == 10'h000)
      else $error("masked pin raised a change report");
endmodule

bind ucg_gpio ucg_gpio_chk #(.NPINS(NPINS)) ucg_gpio_chk_inst (
   .clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
   .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .tx_active(tx_active), .cts_ok(cts_ok), .pin_state(pin_state),
   .irq_request(irq_request), .irq_pins(irq_pins)
);

`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the pin control block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   logic clock, reset, wr_en, rd_en, tx_active, addr_match, bit_tick, cts_ok, dsr_ok, irq_request;
   logic rx_char, tx_char, clk_out_level, rts_request, dtr_request;
   logic [7:0]  addr;
   logic [15:0] wr_data, rd_data;
   logic [9:0]  pin_in, pin_out, pin_oe, pin_state, irq_pins, ext;
   int err_total, comparisons, cycles;

   ucg_gpio ucg_gpio_inst (.clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .tx_active(tx_active), .addr_match(addr_match), .bit_tick(bit_tick),
      .rx_char(rx_char), .tx_char(tx_char), .clk_out_level(clk_out_level),
      .rts_request(rts_request), .dtr_request(dtr_request), .cts_ok(cts_ok), .dsr_ok(dsr_ok),
      .pin_state(pin_state), .irq_request(irq_request), .irq_pins(irq_pins));
   ucg_pad_model ucg_pad_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
      .pin_in(pin_in));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         report_and_stop();
      end
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic ck(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d); // upper bits kept 0
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      ck(rd_data, e);
   endtask
   task automatic tick;
      @(posedge clock);
      bit_tick <= 1'b1;
      @(posedge clock);
      bit_tick <= 1'b0;
   endtask
   task automatic watch(output logic hit);
      hit = 1'b0;
      repeat (6) begin
         @(posedge clock);
         #1;
         if (irq_request === 1'b1 && irq_pins[3] === 1'b1) hit = 1'b1;
      end
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset;
      ck({6'h0, pin_oe}, 16'h0300);
      rd(8'h0C, 16'h0300);
      rd(8'h0D, 16'h0000);
      rd(8'h11, 16'h0100);
      rd(8'h0E, 16'h0000);
      rd(8'h20, 16'h0000);
      $display("reset test done");
   endtask
   task automatic t_gpio;
      wr(8'h0D, 16'h0003);
      cyc(3);
      wr(8'h0E, 16'h03FF);
      cyc(6);
      rd(8'h10, 16'h0003);
      wr(8'h0F, 16'h0001);
      cyc(6);
      rd(8'h10, 16'h0002);
      wr(8'h10, 16'h0001);
      @(posedge clock);
      ext <= 10'h00C;
      cyc(6);
      rd(8'h10, 16'h000D);
      $display("gpio test done");
   endtask
   task automatic t_irq;
      logic hit;
      wr(8'h11, 16'h0000);
      @(posedge clock);
      ext <= 10'h004;
      watch(hit);
      ck({15'h0, hit}, 16'h0001);
      wr(8'h11, 16'h0008);
      @(posedge clock);
      ext <= 10'h00C;
      watch(hit);
      ck({15'h0, hit}, 16'h0000);
      rd(8'h10, 16'h000D);
      $display("change test done");
   endtask
   task automatic t_de;
      wr(8'h0B, 16'h0002);
      wr(8'h0C, 16'h030B);
      @(posedge clock);
      tx_active <= 1'b1;
      cyc(3);
      ck({14'h0, pin_oe[5], pin_out[5]}, 16'h0003);
      @(posedge clock);
      tx_active <= 1'b0;
      cyc(3);
      ck({14'h0, pin_oe[5], pin_out[5]}, 16'h0003);
      tick();
      cyc(3);
      ck({14'h0, pin_oe[5], pin_out[5]}, 16'h0003);
      tick();
      cyc(3);
      ck({14'h0, pin_oe[5], pin_out[5]}, 16'h0002);
      wr(8'h0C, 16'h0303);
      cyc(3);
      ck({14'h0, pin_oe[5], pin_out[5]}, 16'h0003);
      $display("enable test done");
   endtask
   task automatic t_p7;
      wr(8'h0C, 16'h0350); // pin 5 general, pin 7 on address match
      @(posedge clock);
      addr_match <= 1'b1;
      cyc(3);
      ck({14'h0, pin_oe[7], pin_out[7]}, 16'h0002);
      @(posedge clock);
      addr_match <= 1'b0;
      cyc(3);
      ck({14'h0, pin_oe[7], pin_out[7]}, 16'h0003);
      wr(8'h0C, 16'h0340);
      cyc(3);
      ck({15'h0, pin_oe[7]}, 16'h0000);
      wr(8'h0C, 16'h0301);
      cyc(5);
      ck({14'h0, cts_ok, pin_out[5]}, 16'h0003);
      @(posedge clock);
      ext <= 10'h01C;
      rts_request <= 1'b1;
      cyc(5);
      ck({14'h0, cts_ok, pin_out[5]}, 16'h0000);
      $display("pin seven and handshake test done");
   endtask

   task automatic t_alt;
      @(posedge clock);
      rx_char <= 1'b1;
      @(posedge clock);
      rx_char <= 1'b0;
      cyc(3);
      ck({14'h0, pin_out[9:8]}, 16'h0002);
      @(posedge clock);
      {rx_char, tx_char} <= 2'h3;
      @(posedge clock);
      {rx_char, tx_char} <= 2'h0;
      cyc(3);
      ck({14'h0, pin_out[9:8]}, 16'h0001);
      wr(8'h0C, 16'h00B4); // pin 5 on address match, pin 7 on transmit
      @(posedge clock);
      {tx_active, clk_out_level} <= 2'h3;
      cyc(3);
      ck({8'h0, pin_oe[9:5], pin_out[7:5]}, 16'h003B);
      @(posedge clock);
      {tx_active, addr_match} <= 2'h1;
      cyc(3);
      ck({14'h0, pin_out[7], pin_out[5]}, 16'h0000);
      wr(8'h0C, 16'h0002);
      @(posedge clock);
      dtr_request <= 1'b1;
      ext <= 10'h014;
      cyc(5);
      ck({12'h0, dsr_ok, pin_oe[3:2], pin_out[2]}, 16'h000A);
      $display("alternate function test done");
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      {reset, wr_en, rd_en, tx_active, addr_match, bit_tick} = 6'b100000;
      {rx_char, tx_char, clk_out_level, rts_request, dtr_request} = 5'h00;
      addr = 8'h00;
      wr_data = 16'h0000;
      ext = 10'h000;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      cyc(3);
      t_reset();
      t_gpio();
      t_irq();
      t_de();
      t_p7();
      t_alt();
      report_and_stop();
   end
endmodule

`default_nettype wire
